// >>> design/emi_regs.svh
`ifndef EMI_REGS_SVH
`define EMI_REGS_SVH

// ----------------------------------------
// register fields and reset values
// ----------------------------------------
`define EMI_PAGE_RESET 8'h00
`define EMI_CFG_RESET 8'h03
`define EMI_CFG_WR_MASK 8'h3F
`define EMI_CFG_BANK_BIT 5
`define EMI_CFG_MUX_BIT 4
`define EMI_CFG_MODE_HI 3
`define EMI_CFG_MODE_LO 2
`define EMI_CFG_ALE_HI 1
`define EMI_CFG_ALE_LO 0

// ----------------------------------------
// address map and timing
// ----------------------------------------
`define EMI_ONCHIP_BITS 12
`define EMI_STROBE_CYCLES 4

// ----------------------------------------
// pin positions within a bank of four ports
// ----------------------------------------
`define EMI_PIN_WR 7
`define EMI_PIN_RD 6
`define EMI_PIN_ALE 5
`define EMI_BANK_WIDTH 32
`endif

// >>> design/emi_pkg.sv
package emi_pkg;
  typedef enum logic [1:0] {
    emi_mode_onchip = 2'h0,
    emi_mode_split_nobank = 2'h1,
    emi_mode_split_bank = 2'h2,
    emi_mode_offchip = 2'h3
  } emi_mode_t;

  typedef enum logic [2:0] {
    emi_st_idle = 3'h0,
    emi_st_ale_high = 3'h1,
    emi_st_ale_low = 3'h3,
    emi_st_strobe = 3'h2,
    emi_st_done = 3'h6,
    emi_st_onchip = 3'h4
  } emi_state_t;
endpackage : emi_pkg

// >>> design/emi_bus_if.sv
`timescale 1ns/1ps
interface emi_bus_if;
  logic claim;
  logic bank_upper;
  logic mux_sep;
  logic drive_high;
  logic addr_phase;
  logic data_oe;
  logic ale;
  logic rd_n;
  logic wr_n;
  logic [7:0] addr_high;
  logic [7:0] addr_low;
  logic [7:0] dout;
  logic [7:0] din;

  modport engine (
    output claim, bank_upper, mux_sep, drive_high, addr_phase, data_oe,
    output ale, rd_n, wr_n, addr_high, addr_low, dout,
    input din
  );
  modport pins (
    input claim, bank_upper, mux_sep, drive_high, addr_phase, data_oe,
    input ale, rd_n, wr_n, addr_high, addr_low, dout,
    output din
  );
endinterface : emi_bus_if

// >>> design/emi_pin_mux.sv
`timescale 1ns/1ps
`include "emi_regs.svh"
module emi_pin_mux (
  input wire logic ref_clk,
  input wire logic rst_b,
  emi_bus_if.pins bus,
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe,
  output logic [63:0] pin_own
);
  logic [15:0] sync_a;
  logic [15:0] sync_b;
  logic [31:0] o32;
  logic [31:0] e32;
  logic [31:0] w32;

  // ----------------------------------------
  // data pins: two-stage sync of both banks
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= 16'h0000;
      sync_b <= 16'h0000;
    end else begin
      sync_a <= {pin_in[63:56], pin_in[31:24]};
      sync_b <= sync_a;
    end
  end
  assign bus.din = bus.bank_upper ? sync_b[15:8] : sync_b[7:0];

  // ----------------------------------------
  // per-bank routing
  // ----------------------------------------
  always_comb begin
    o32 = 32'h0000_0000;
    e32 = 32'h0000_0000;
    w32 = 32'h0000_0000;
    // released pins stay with the port latches / crossbar
    if (bus.claim) begin
      o32[`EMI_PIN_WR] = bus.wr_n;
      o32[`EMI_PIN_RD] = bus.rd_n;
      w32[`EMI_PIN_WR] = 1'b1;
      w32[`EMI_PIN_RD] = 1'b1;
      o32[23:16] = bus.addr_high;
      // short move in split-no-bank leaves upper address to the latches
      w32[23:16] = {8{bus.drive_high}};
      w32[31:24] = 8'hFF;
      if (!bus.mux_sep) begin
        o32[`EMI_PIN_ALE] = bus.ale;
        w32[`EMI_PIN_ALE] = 1'b1;
        o32[31:24] = bus.addr_phase ? bus.addr_low : bus.dout;
        e32[31:24] = {8{bus.addr_phase | bus.data_oe}};
      end else begin
        o32[15:8] = bus.addr_low;
        w32[15:8] = 8'hFF;
        o32[31:24] = bus.dout;
        e32[31:24] = {8{bus.data_oe}};
      end
      e32[23:0] = w32[23:0];
    end
  end

  // only level, enable and ownership leave here; output mode stays the port's
  always_comb begin
    if (bus.bank_upper) begin
      pin_out = {o32, 32'h0000_0000};
      pin_oe = {e32, 32'h0000_0000};
      pin_own = {w32, 32'h0000_0000};
    end else begin
      pin_out = {32'h0000_0000, o32};
      pin_oe = {32'h0000_0000, e32};
      pin_own = {32'h0000_0000, w32};
    end
  end
endmodule : emi_pin_mux

// >>> design/emi_ctrl.sv
`timescale 1ns/1ps
`include "emi_regs.svh"
module emi_ctrl #(
  parameter int STROBE_CYCLES = `EMI_STROBE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic page_wr_en,
  input wire logic cfg_wr_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] xram_page_high_byte,
  output logic [7:0] ext_memory_configuration,
  input wire logic move_req,
  input wire logic move_we,
  input wire logic move_short,
  input wire logic [15:0] move_ptr,
  input wire logic [7:0] move_low,
  input wire logic [7:0] move_wdata,
  output logic move_busy,
  output logic move_ack,
  output logic [7:0] move_rdata,
  output logic xram_req,
  output logic xram_we,
  output logic [11:0] xram_addr,
  output logic [7:0] xram_wdata,
  input wire logic [7:0] xram_rdata,
  input wire logic [63:0] pin_in,
  output logic [63:0] pin_out,
  output logic [63:0] pin_oe,
  output logic [63:0] pin_own
);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);

  emi_bus_if bus ();

  emi_pin_mux u_pins (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .bus(bus),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe),
    .pin_own(pin_own)
  );

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [7:0] page_q;
  logic [7:0] cfg_q;
  logic [7:0] next_page;
  logic [7:0] next_cfg;

  always_comb begin
    next_page = page_q;
    next_cfg = cfg_q;
    if (page_wr_en) begin
      next_page = sfr_wdata;
    end
    // top two bits unused, always read zero
    if (cfg_wr_en) begin
      next_cfg = sfr_wdata & `EMI_CFG_WR_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_q <= `EMI_PAGE_RESET;
      cfg_q <= `EMI_CFG_RESET;
    end else begin
      page_q <= next_page;
      cfg_q <= next_cfg;
    end
  end
  assign xram_page_high_byte = page_q;
  assign ext_memory_configuration = cfg_q;

  // ----------------------------------------
  // address decode of a new request
  // ----------------------------------------
  emi_pkg::emi_mode_t mode;
  logic [15:0] eff_addr;
  logic above_4k;
  logic go_off;
  logic [7:0] ale_last;

  assign mode = emi_pkg::emi_mode_t'(cfg_q[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO]);
  assign eff_addr = move_short ? {page_q, move_low} : move_ptr;
  assign above_4k = |eff_addr[15:`EMI_ONCHIP_BITS];
  assign ale_last = {6'h00, cfg_q[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO]};

  always_comb begin
    unique case (mode)
      emi_pkg::emi_mode_onchip: go_off = 1'b0;
      emi_pkg::emi_mode_split_nobank: go_off = above_4k;
      emi_pkg::emi_mode_split_bank: go_off = above_4k;
      emi_pkg::emi_mode_offchip: go_off = 1'b1;
    endcase
  end

  // ----------------------------------------
  // access sequencer
  // ----------------------------------------
  emi_pkg::emi_state_t state;
  emi_pkg::emi_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] ale_len;
  logic [7:0] next_ale_len;
  logic we_q;
  logic next_we;
  logic bank_q;
  logic next_bank;
  logic sep_q;
  logic next_sep;
  logic hi_q;
  logic next_hi;
  logic [15:0] addr_q;
  logic [15:0] next_addr;
  logic [7:0] dout_q;
  logic [7:0] next_dout;
  logic [7:0] rdata_q;
  logic [7:0] next_rdata;
  logic ack_q;
  logic next_ack;
  logic xreq_q;
  logic next_xreq;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_ale_len = ale_len;
    next_we = we_q;
    next_bank = bank_q;
    next_sep = sep_q;
    next_hi = hi_q;
    next_addr = addr_q;
    next_dout = dout_q;
    next_rdata = rdata_q;
    next_ack = 1'b0;
    next_xreq = 1'b0;
    unique case (state)
      emi_pkg::emi_st_idle: begin
        if (move_req) begin
          next_we = move_we;
          next_addr = eff_addr;
          next_dout = move_wdata;
          if (!go_off) begin
            // on-chip hit: pins stay untouched
            next_xreq = 1'b1;
            next_state = emi_pkg::emi_st_onchip;
          end else begin
            // routing frozen for the whole access so a config write
            // mid-cycle cannot glitch the pins
            next_bank = cfg_q[`EMI_CFG_BANK_BIT];
            next_sep = cfg_q[`EMI_CFG_MUX_BIT];
            next_hi = !(move_short && mode == emi_pkg::emi_mode_split_nobank);
            next_ale_len = ale_last;
            if (!cfg_q[`EMI_CFG_MUX_BIT]) begin
              next_cnt = ale_last;
              next_state = emi_pkg::emi_st_ale_high;
            end else begin
              next_cnt = STROBE_LAST;
              next_state = emi_pkg::emi_st_strobe;
            end
          end
        end
      end
      emi_pkg::emi_st_ale_high: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_cnt = ale_len;
          next_state = emi_pkg::emi_st_ale_low;
        end
      end
      emi_pkg::emi_st_ale_low: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_cnt = STROBE_LAST;
          next_state = emi_pkg::emi_st_strobe;
        end
      end
      emi_pkg::emi_st_strobe: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          // strobe kept long enough to cover the two-stage sync
          next_rdata = we_q ? rdata_q : bus.din;
          next_state = emi_pkg::emi_st_done;
        end
      end
      emi_pkg::emi_st_onchip: begin
        next_state = emi_pkg::emi_st_done;
      end
      emi_pkg::emi_st_done: begin
        next_ack = 1'b1;
        next_state = emi_pkg::emi_st_idle;
      end
      default: begin
        next_state = emi_pkg::emi_st_idle;
      end
    endcase
  end

  // on-chip ram answers within the request cycle
  logic onchip_cap;
  assign onchip_cap = (state == emi_pkg::emi_st_onchip) && !we_q;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= emi_pkg::emi_st_idle;
      cnt <= 8'h00;
      ale_len <= 8'h00;
      we_q <= 1'b0;
      bank_q <= 1'b0;
      sep_q <= 1'b0;
      hi_q <= 1'b0;
      addr_q <= 16'h0000;
      dout_q <= 8'h00;
      rdata_q <= 8'h00;
      ack_q <= 1'b0;
      xreq_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      ale_len <= next_ale_len;
      we_q <= next_we;
      bank_q <= next_bank;
      sep_q <= next_sep;
      hi_q <= next_hi;
      addr_q <= next_addr;
      dout_q <= next_dout;
      rdata_q <= onchip_cap ? xram_rdata : next_rdata;
      ack_q <= next_ack;
      xreq_q <= next_xreq;
    end
  end

  // ----------------------------------------
  // outputs to cpu, on-chip ram and pins
  // ----------------------------------------
  assign move_busy = (state != emi_pkg::emi_st_idle);
  assign move_ack = ack_q;
  assign move_rdata = rdata_q;
  assign xram_req = xreq_q;
  assign xram_we = we_q;
  assign xram_addr = addr_q[11:0]; // on-chip space wraps every 4k
  assign xram_wdata = dout_q;

  // remember whether the current done cycle ends an on-chip access
  logic onchip_done_q;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      onchip_done_q <= 1'b0;
    end else begin
      onchip_done_q <= (state == emi_pkg::emi_st_onchip);
    end
  end

  logic off_active;
  assign off_active = (state == emi_pkg::emi_st_ale_high) ||
                      (state == emi_pkg::emi_st_ale_low) ||
                      (state == emi_pkg::emi_st_strobe) ||
                      (state == emi_pkg::emi_st_done && !onchip_done_q);

  assign bus.claim = off_active;
  assign bus.bank_upper = bank_q;
  assign bus.mux_sep = sep_q;
  assign bus.drive_high = hi_q;
  assign bus.addr_phase = (state == emi_pkg::emi_st_ale_high) ||
                          (state == emi_pkg::emi_st_ale_low);
  // write data driven only in strobe and hold; reads leave the bus released
  assign bus.data_oe = we_q && ((state == emi_pkg::emi_st_strobe) ||
                                (state == emi_pkg::emi_st_done));
  assign bus.ale = (state == emi_pkg::emi_st_ale_high);
  assign bus.rd_n = !((state == emi_pkg::emi_st_strobe) && !we_q);
  assign bus.wr_n = !((state == emi_pkg::emi_st_strobe) && we_q);
  assign bus.addr_high = addr_q[15:8];
  assign bus.addr_low = addr_q[7:0];
  assign bus.dout = dout_q;
endmodule : emi_ctrl

// >>> verification/emi_ext_sram.sv
`timescale 1ns/1ps
module emi_ext_sram (
  input wire logic ref_clk,
  input wire logic upper,
  input wire logic sep,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  output logic [63:0] pin_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] alo;
  logic [7:0] dlast = 8'h5A;
  logic [31:0] po;
  logic [31:0] pe;
  logic [31:0] pins;
  logic [15:0] adr;
  assign po = upper ? pin_out[63:32] : pin_out[31:0];
  assign pe = upper ? pin_oe[63:32] : pin_oe[31:0];
  // undriven high address lines show the parked latch level
  assign adr = {(po[23:16] & pe[23:16]) | ~pe[23:16], sep ? po[15:8] : alo};
  always @(posedge ref_clk) begin
    if (!sep && pe[5] && po[5]) alo <= po[31:24];
    if (pe[7] && !po[7]) mem[adr] <= po[31:24];
    if (pe[31:24] != 8'h00) dlast <= po[31:24];
  end
  always_comb begin
    // released lines sit at the parked latch level of one
    pins = (pe & po) | ~pe;
    if (pe[31:24] == 8'h00) begin
      // a floating bus must not look like the last value
      pins[31:24] = (pe[6] && !po[6]) ? mem[adr] : ~dlast;
    end
    pin_in = upper ? {pins, 32'hFFFF_FFFF} : {32'hFFFF_FFFF, pins};
  end
endmodule : emi_ext_sram

// >>> verification/emi_ctrl_monitor.sv
`timescale 1ns/1ps
module emi_ctrl_monitor #(
  parameter int STROBE_CYCLES = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic move_req,
  input wire logic move_busy,
  input wire logic move_ack,
  input wire logic xram_req,
  input wire logic [7:0] ext_memory_configuration,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe,
  input wire logic [63:0] pin_own
);
  logic take;
  logic ale;
  logic [7:0] cfg;
  logic [7:0] cnt, next_cnt, ale_cnt, next_ale_cnt;
  logic [3:0] mode_tk, next_mode_tk;
  assign cfg = ext_memory_configuration;
  assign take = move_req && !move_busy;
  assign ale = (pin_own[5] & pin_out[5]) | (pin_own[37] & pin_out[37]);
  always_comb begin
    // the take edge counts as the first cycle of the access
    next_cnt = take ? 8'h01 : cnt + 8'h01;
    next_ale_cnt = ale ? ale_cnt + 8'h01 : 8'h00;
    next_mode_tk = take ? {cfg[4], cfg[3:2] == 2'b11, cfg[1:0]} : mode_tk;
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      ale_cnt <= 8'h00;
      mode_tk <= 4'h0;
    end else begin
      cnt <= next_cnt;
      ale_cnt <= next_ale_cnt;
      mode_tk <= next_mode_tk;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_idle_no_own: assert property (!move_busy |-> pin_own == '0)
    else $error("pins owned while idle");
  a_onchip_no_pins: assert property (xram_req |-> (pin_own == '0) [*3] ##0 move_ack)
    else $error("on-chip access touched pins");
  a_one_bank: assert property (!((|pin_own[31:0]) && (|pin_own[63:32])))
    else $error("both banks owned");
  a_rd_lo_inputs: assert property ((pin_own[6] && !pin_out[6]) |-> pin_oe[31:24] == '0)
    else $error("lower data driven during read");
  a_rd_hi_inputs: assert property ((pin_own[38] && !pin_out[38]) |-> pin_oe[63:56] == '0)
    else $error("upper data driven during read");
  a_onchip_mode: assert property (take && cfg[3:2] == 2'b00 |=> xram_req)
    else $error("mode 00 did not go on-chip");
  a_ale_high: assert property ($fell(ale) |-> ale_cnt == {6'h00, mode_tk[1:0]} + 8'h01)
    else $error("ALE high width wrong");
  a_sep_timing: assert property (move_ack && mode_tk[3:2] == 2'b11 |-> cnt == 8'(STROBE_CYCLES + 2))
    else $error("separate access length wrong");
  a_mux_timing: assert property (move_ack && mode_tk[3:2] == 2'b01 |->
    cnt == 8'((mode_tk[1:0] + 1) * 2 + STROBE_CYCLES + 2))
    else $error("multiplexed access length wrong");
  c_onchip: cover property (xram_req);
  c_ale: cover property ($fell(ale));
  c_sep: cover property (move_ack && mode_tk[3:2] == 2'b11);
endmodule : emi_ctrl_monitor
bind emi_ctrl emi_ctrl_monitor #(.STROBE_CYCLES(STROBE_CYCLES)) u_mon (
  .ref_clk(ref_clk), .rst_b(rst_b), .move_req(move_req), .move_busy(move_busy),
  .move_ack(move_ack), .xram_req(xram_req), .ext_memory_configuration(ext_memory_configuration),
  .pin_out(pin_out), .pin_oe(pin_oe), .pin_own(pin_own)
);

// >>> verification/tb_ext_memory_iface_config.sv
`timescale 1ns/1ps
module tb_ext_memory_iface_config;
  logic ref_clk, rst_b, page_wr_en, cfg_wr_en, move_req, move_we, move_short;
  logic move_busy, move_ack, xram_req, xram_we;
  logic [7:0] sfr_wdata, xram_page_high_byte, ext_memory_configuration, move_low, move_wdata;
  logic [7:0] move_rdata, xram_wdata, xram_rdata, cfg_v;
  logic [15:0] move_ptr;
  logic [11:0] xram_addr;
  logic [63:0] pin_in, pin_out, pin_oe, pin_own;
  logic [7:0] ram [0:4095];
  int miscompares, checked;

  emi_ctrl uut (.ref_clk(ref_clk), .rst_b(rst_b), .page_wr_en(page_wr_en),
    .cfg_wr_en(cfg_wr_en), .sfr_wdata(sfr_wdata), .xram_page_high_byte(xram_page_high_byte),
    .ext_memory_configuration(ext_memory_configuration), .move_req(move_req),
    .move_we(move_we), .move_short(move_short), .move_ptr(move_ptr), .move_low(move_low),
    .move_wdata(move_wdata), .move_busy(move_busy), .move_ack(move_ack),
    .move_rdata(move_rdata), .xram_req(xram_req), .xram_we(xram_we), .xram_addr(xram_addr),
    .xram_wdata(xram_wdata), .xram_rdata(xram_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_own(pin_own));
  emi_ext_sram u_far (.ref_clk(ref_clk), .upper(cfg_v[5]), .sep(cfg_v[4]),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (xram_req && xram_we) ram[xram_addr] <= xram_wdata;
  end
  // read data must stand in the request cycle, where the sequencer takes it
  assign xram_rdata = ram[xram_addr];

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic sfr(input logic pg, input logic [7:0] v);
    @(posedge ref_clk);
    page_wr_en <= pg;
    cfg_wr_en <= !pg;
    sfr_wdata <= v;
    if (!pg) cfg_v <= v;
    @(posedge ref_clk);
    page_wr_en <= 1'b0;
    cfg_wr_en <= 1'b0;
    #1;
  endtask : sfr

  task automatic move(input logic we, input logic sh, input logic [15:0] a,
      input logic [7:0] d, input int lat, input logic [1:0] own);
    int n;
    logic [1:0] seen;
    // the edge that samples the request counts too
    n = 1;
    seen = 2'b00;
    @(posedge ref_clk);
    move_req <= 1'b1;
    move_we <= we;
    move_short <= sh;
    move_ptr <= sh ? ~a : a;
    move_low <= a[7:0];
    move_wdata <= d;
    @(posedge ref_clk);
    move_req <= 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      seen = seen | {|pin_own[63:32], |pin_own[31:0]};
    end while (move_ack !== 1'b1 && n < 100);
    chk(16'(n), 16'(lat));
    chk({14'h0000, seen}, {14'h0000, own});
    if (!we) chk({8'h00, move_rdata}, {8'h00, d});
  endtask : move

  task automatic wrap_up;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    rst_b = 1'b0;
    page_wr_en = 1'b0;
    cfg_wr_en = 1'b0;
    sfr_wdata = 8'h00;
    move_req = 1'b0;
    move_we = 1'b0;
    move_short = 1'b0;
    move_ptr = 16'h0000;
    move_low = 8'h00;
    move_wdata = 8'h00;
    cfg_v = 8'h03;
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk({8'h00, xram_page_high_byte}, 16'h0000);
    chk({8'h00, ext_memory_configuration}, 16'h0003);
    sfr(1'b0, 8'hFF);
    chk({8'h00, ext_memory_configuration}, 16'h003F);
    $display("test registers done");
    sfr(1'b0, 8'h00);
    move(1'b1, 1'b0, 16'h1234, 8'h5C, 3, 2'b00);
    move(1'b0, 1'b0, 16'h0234, 8'h5C, 3, 2'b00);
    $display("test on-chip done");
    for (int b = 0; b < 2; b++) begin
      for (int w = 0; w < 4; w++) begin
        sfr(1'b0, {2'b00, b[0], 1'b0, 2'b11, w[1:0]});
        move(1'b1, 1'b0, {8'h80, 5'h00, b[0], w[1:0]}, {4'hA, 2'b00, w[1:0]},
          (w + 1) * 2 + 6, b ? 2'b10 : 2'b01);
        move(1'b0, 1'b0, {8'h80, 5'h00, b[0], w[1:0]}, {4'hA, 2'b00, w[1:0]},
          (w + 1) * 2 + 6, b ? 2'b10 : 2'b01);
      end
      sfr(1'b0, {2'b00, b[0], 1'b1, 2'b11, 2'b00});
      move(1'b1, 1'b0, {8'h90, 7'h00, b[0]}, 8'h3B, 6, b ? 2'b10 : 2'b01);
      move(1'b0, 1'b0, {8'h90, 7'h00, b[0]}, 8'h3B, 6, b ? 2'b10 : 2'b01);
    end
    $display("test off-chip done");
    sfr(1'b0, 8'h14);
    move(1'b1, 1'b0, 16'h0FFF, 8'h11, 3, 2'b00);
    move(1'b1, 1'b0, 16'h1000, 8'h22, 6, 2'b01);
    move(1'b0, 1'b0, 16'h0FFF, 8'h11, 3, 2'b00);
    move(1'b0, 1'b0, 16'h1000, 8'h22, 6, 2'b01);
    $display("test split done");
    sfr(1'b1, 8'h9A);
    chk({8'h00, xram_page_high_byte}, 16'h009A);
    sfr(1'b0, 8'h1C);
    move(1'b1, 1'b1, 16'h9A3C, 8'h77, 6, 2'b01);
    move(1'b0, 1'b0, 16'h9A3C, 8'h77, 6, 2'b01);
    $display("test page done");
    sfr(1'b0, 8'h14);
    move(1'b1, 1'b1, 16'h9A55, 8'h66, 6, 2'b01);
    sfr(1'b0, 8'h1C);
    move(1'b0, 1'b0, 16'hFF55, 8'h66, 6, 2'b01);
    sfr(1'b0, 8'h18);
    move(1'b1, 1'b0, 16'h2000, 8'h44, 6, 2'b01);
    move(1'b0, 1'b0, 16'h2000, 8'h44, 6, 2'b01);
    move(1'b0, 1'b0, 16'h0FFF, 8'h11, 3, 2'b00);
    $display("test modes done");
    wrap_up();
  end

  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule : tb_ext_memory_iface_config
